// ---- can_mode_ctrl.sv ----
// Purpose: CAN mode controller, test mode pin routing and transmit mailboxes
// Assumes: Protocol core is external and reports bus idle and attempt results
// Notes:   Avalon-MM slave, one wait state per access
//
// Contract
// RQ1 - After reset the controller sits in sleep mode.
// RQ2 - Init and sleep requests are confirmed by matching acknowledge flags.
// RQ3 - Normal operation starts only after 11 consecutive recessive bits.
// RQ4 - Clearing init request drops init acknowledge, then bus sync follows.
// RQ5 - In init all transfers stop and transmit pin is recessive.
// RQ6 - Entering init leaves all configuration registers untouched.
// RQ7 - Software should keep unused filter banks inactive.
// RQ8 - Software writes filters only when inactive, scale only in init.
// RQ9 - Sleep stops the core clock; registers stay accessible, status frozen.
// RQ10 - Init request during sleep is not acknowledged.
// RQ11 - Sleep exits by software clear or bus activity with auto-wakeup.
// RQ12 - Bus activity raises wake-up interrupt when enabled, even with auto-wakeup.
// RQ13 - Sleep acknowledge clears only after bus synchronization; code also clears it on an init request during sync.
// RQ14 - Test mode bits are written in init; device then runs normal.
// RQ15 - Silent mode receives, never transmits, routes dominant bits internally.
// RQ16 - Loop-back feeds transmit to receive, ignores receive pin, pin shows traffic.
// RQ17 - Loop-back suppresses acknowledge errors.
// RQ18 - Loop-back plus silent disconnects receive pin and holds transmit recessive.
// RQ19 - Mailbox is written while empty; locked once it leaves empty.
// RQ20 - Mailbox goes pending, scheduled, transmit, then empty on success.
// RQ21 - Success sets request-complete and transmit-success in both status views.
// RQ22 - Failure sets arbitration-lost and/or transmit-error flags.
// RQ23 - Lowest identifier wins; equal identifiers pick the lower mailbox.
// RQ24 - Wake-up is a dominant receive level sampled on the free-running clock.
`timescale 1ns/1ps
`default_nettype none
module can_mode_ctrl
    import can_mode_pkg::*;
(
    input  wire logic        clk_sys_i,          // 200 MHz system clock
    input  wire logic        rst_i,              // Sync reset, high
    input  wire logic        ce_i,               // Clock enable
    input  wire logic [7:0]  avs_address_i,      // Byte address
    input  wire logic        avs_read_i,         // Read request
    input  wire logic        avs_write_i,        // Write request
    input  wire logic [31:0] avs_writedata_i,    // Write data
    input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
    output logic [31:0]      avs_readdata_o,     // Read data, registered
    output logic             avs_waitrequest_o,  // Stall
    input  wire logic        rx_pin_i,           // Transceiver receive level
    output logic             tx_pin_o,           // Transceiver transmit level
    output logic             core_clk_en_o,      // Core clock enable, low in sleep
    output logic             core_active_o,      // Core may receive and transmit
    input  wire logic        core_tx_bit_i,      // Bit the core drives
    output logic             core_rx_bit_o,      // Bit the core sees
    input  wire logic        bit_tick_i,         // Sample point strobe
    input  wire logic        core_bus_idle_i,    // Core sees bus idle
    output logic             ack_err_off_o,      // Ignore acknowledge errors
    output tx_frame_t        tx_frame_o,         // Frame to send, registered
    output logic             tx_start_o,         // Start pulse
    input  wire tx_result_t  tx_result_i,        // Attempt outcome
    output logic             wakeup_irq_o        // Wake-up interrupt level
);
    mode_t       mode_q;
    logic        init_req_q;
    logic        sleep_req_q;
    logic        auto_wake_q;
    logic        lowpower_acknowledge_q;
    logic        wake_flag_q;
    logic        wake_ie_q;
    logic        silent_q;
    logic        loopback_q;
    logic        sync_idle;
    logic        sync_restart;
    logic        bus_active;
    logic        ack_q;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] wmask;
    logic [31:0] rdata_d;
    logic [31:0] id_q    [NUM_MBOX];
    logic [3:0]  dlc_q   [NUM_MBOX];
    logic [63:0] data_q  [NUM_MBOX];
    mb_state_t   mb_st   [NUM_MBOX];
    logic [3:0]  mb_flg  [NUM_MBOX];
    logic [NUM_MBOX-1:0] mb_req;
    logic [NUM_MBOX-1:0] mb_win;
    logic        win_valid;
    logic        win_idx;
    logic        tx_busy;
    logic        tx_idx_q;
    logic        start_ok;
    logic        mb_hit;
    logic        mb_sel;
    logic [2:0]  mb_fld;

    // Bus slave: every access sees exactly one wait state
    assign rd_en = avs_read_i && !ack_q && ce_i;
    assign wr_en = avs_write_i && !ack_q && ce_i;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign mb_hit = (avs_address_i[7:6] == MB_REGION);
    assign mb_sel = avs_address_i[5];
    assign mb_fld = avs_address_i[4:2];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    // Wake-up seen on the free-running clock, core clock may be off
    assign bus_active = (mode_q == MODE_SLEEP) && !rx_pin_i; // RQ24

    // Control register; mode changes never touch configuration
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {auto_wake_q, sleep_req_q, init_req_q} <= MCR_RESET;
        end else if (ce_i) begin
            if (wr_en && !mb_hit && avs_address_i == OFS_MCR && avs_byteenable_i[0]) begin
                init_req_q  <= avs_writedata_i[MCR_INIT_BIT];
                sleep_req_q <= avs_writedata_i[MCR_SLEEP_BIT];
                auto_wake_q <= avs_writedata_i[MCR_AWAKE_BIT];
            end
            if (bus_active && auto_wake_q) begin
                sleep_req_q <= 1'b0; // RQ11
            end
        end
    end

    // Diagnostic bits only taken while in init
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {loopback_q, silent_q} <= DIAG_RESET;
        end else if (ce_i) begin
            if (wr_en && !mb_hit && avs_address_i == OFS_DIAG && avs_byteenable_i[0]
                && mode_q == MODE_INIT) begin
                silent_q   <= avs_writedata_i[DIAG_SIL_BIT];  // RQ14
                loopback_q <= avs_writedata_i[DIAG_LBK_BIT];  // RQ14
            end
        end
    end

    // Wake flag: hardware set wins over a write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_flag_q <= 1'b0;
            wake_ie_q   <= 1'b0;
        end else if (ce_i) begin
            if (wr_en && !mb_hit && avs_address_i == OFS_IER && avs_byteenable_i[0]) begin
                wake_ie_q <= avs_writedata_i[IER_WAKE_BIT];
            end
            if (bus_active) begin
                wake_flag_q <= 1'b1; // RQ12
            end else if (wr_en && !mb_hit && avs_address_i == OFS_MSR && avs_byteenable_i[0]
                         && avs_writedata_i[MSR_WAKE_BIT]) begin
                wake_flag_q <= 1'b0;
            end
        end
    end

    assign wakeup_irq_o = wake_flag_q && wake_ie_q; // RQ12

    // Mode sequencing
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= MODE_SLEEP; // RQ1
            lowpower_acknowledge_q <= 1'b1;       // RQ1
        end else if (ce_i) begin
            unique case (mode_q)
                MODE_SLEEP: begin
                    if (!sleep_req_q) begin
                        mode_q <= MODE_SYNC; // RQ11
                    end
                end
                MODE_INIT: begin
                    if (!init_req_q) begin
                        mode_q <= MODE_SYNC; // RQ4
                    end
                end
                MODE_SYNC: begin
                    if (init_req_q) begin
                        mode_q <= MODE_INIT; // RQ2 RQ6
                        lowpower_acknowledge_q <= 1'b0;
                    end else if (sleep_req_q) begin
                        mode_q <= MODE_SLEEP; // RQ2
                        lowpower_acknowledge_q <= 1'b1;
                    end else if (sync_idle) begin
                        mode_q <= MODE_NORMAL; // RQ3
                        lowpower_acknowledge_q <= 1'b0;        // RQ13
                    end
                end
                MODE_NORMAL: begin
                    if (init_req_q && !tx_busy) begin
                        mode_q <= MODE_INIT; // RQ2
                    end else if (sleep_req_q && !tx_busy) begin
                        mode_q <= MODE_SLEEP; // RQ2
                        lowpower_acknowledge_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign core_clk_en_o = (mode_q != MODE_SLEEP); // RQ9
    assign core_active_o = (mode_q == MODE_NORMAL); // RQ5
    assign sync_restart  = (mode_q != MODE_SYNC);

    can_idle_detect #(
        .BITS       (IDLE_BITS)
    ) u_idle (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .restart_i  (sync_restart),
        .bit_tick_i (bit_tick_i),
        .rx_bit_i   (core_rx_bit_o),
        .idle_o     (sync_idle)
    );

    // Pin routing for init and test modes
    always_comb begin
        if (!core_active_o || silent_q) begin
            tx_pin_o = 1'b1; // RQ5 RQ15 RQ18
        end else begin
            tx_pin_o = core_tx_bit_i; // RQ16
        end
        if (loopback_q) begin
            core_rx_bit_o = core_tx_bit_i; // RQ16 RQ18
        end else if (silent_q) begin
            core_rx_bit_o = rx_pin_i & core_tx_bit_i; // RQ15
        end else begin
            core_rx_bit_o = rx_pin_i;
        end
    end

    assign ack_err_off_o = loopback_q; // RQ17

    // Mailbox contents, writable only while empty
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_MBOX; i++) begin
                id_q[i]   <= 32'h0000_0000;
                dlc_q[i]  <= 4'h0;
                data_q[i] <= 64'h0000_0000_0000_0000;
            end
        end else if (ce_i && wr_en && mb_hit && mb_st[mb_sel] == MB_EMPTY) begin // RQ19
            unique case (mb_fld)
                MBF_ID: begin
                    id_q[mb_sel] <= (id_q[mb_sel] & ~wmask) | (avs_writedata_i & wmask);
                end
                MBF_DLC: begin
                    if (avs_byteenable_i[0]) begin
                        dlc_q[mb_sel] <= avs_writedata_i[3:0];
                    end
                end
                MBF_DATA0: begin
                    data_q[mb_sel][31:0] <= (data_q[mb_sel][31:0] & ~wmask) | (avs_writedata_i & wmask);
                end
                MBF_DATA1: begin
                    data_q[mb_sel][63:32] <= (data_q[mb_sel][63:32] & ~wmask) | (avs_writedata_i & wmask);
                end
                default: begin
                end
            endcase
        end
    end

    // Priority: lowest identifier, mailbox 0 on a tie; ids compare on bits 28:0 as stored
    always_comb begin
        win_valid = 1'b0;
        win_idx   = 1'b0;
        if (mb_st[0] != MB_EMPTY && mb_st[0] != MB_TRANSMIT) begin
            win_valid = 1'b1;
        end
        if (mb_st[1] != MB_EMPTY && mb_st[1] != MB_TRANSMIT) begin
            if (!win_valid || id_q[1][28:0] < id_q[0][28:0]) begin
                win_idx = 1'b1; // RQ23
            end
            win_valid = 1'b1;
        end
    end

    assign tx_busy  = (mb_st[0] == MB_TRANSMIT) || (mb_st[1] == MB_TRANSMIT);
    assign start_ok = win_valid && !tx_busy && core_bus_idle_i && mode_q == MODE_NORMAL
                      && (!silent_q || loopback_q) && mb_st[win_idx] == MB_SCHEDULED; // RQ15 RQ18 RQ20
    assign tx_start_o = start_ok;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_idx_q   <= 1'b0;
            tx_frame_o <= '0;
        end else if (ce_i && start_ok) begin
            tx_idx_q   <= win_idx;
            tx_frame_o <= {id_q[win_idx][28:0], id_q[win_idx][ID_IDE_BIT],
                           dlc_q[win_idx], data_q[win_idx]};
        end
    end

    for (genvar g = 0; g < NUM_MBOX; g++) begin : g_mb
        tx_result_t res;
        logic [3:0] clr;
        logic       req;

        assign req = wr_en && mb_hit && mb_sel == g[0] && mb_fld == MBF_CSR
                     && avs_byteenable_i[0] && avs_writedata_i[CSR_TRANSMIT_REQUEST_BIT]
                     && mb_st[g] == MB_EMPTY; // RQ19
        assign clr = (wr_en && mb_hit && mb_sel == g[0] && mb_fld == MBF_CSR
                      && avs_byteenable_i[0]) ? avs_writedata_i[CSR_FLAG_LSB +: 4] : 4'h0;
        // Results ignored in sleep so status stays frozen
        assign res = (tx_idx_q == g[0] && mode_q != MODE_SLEEP) ? tx_result_i : '0; // RQ9
        assign mb_req[g] = req;
        assign mb_win[g] = win_valid && win_idx == g[0] && mode_q == MODE_NORMAL;

        can_tx_mailbox u_mb (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .ce_i      (ce_i),
            .request_i (mb_req[g]),
            .winner_i  (mb_win[g]),
            .start_i   (start_ok && win_idx == g[0]),
            .result_i  (res),
            .clr_i     (clr),
            .state_o   (mb_st[g]),
            .flags_o   (mb_flg[g])
        );
    end

    // Read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (mb_hit) begin
            unique case (mb_fld)
                MBF_CSR: begin
                    rdata_d[CSR_FLAG_LSB +: 4]  = mb_flg[mb_sel];
                    rdata_d[CSR_STATE_LSB +: 2] = mb_st[mb_sel];
                end
                MBF_ID:    rdata_d = id_q[mb_sel];
                MBF_DLC:   rdata_d[3:0] = dlc_q[mb_sel];
                MBF_DATA0: rdata_d = data_q[mb_sel][31:0];
                MBF_DATA1: rdata_d = data_q[mb_sel][63:32];
                default: begin
                end
            endcase
        end else begin
            unique case (avs_address_i)
                OFS_MCR: rdata_d[2:0] = {auto_wake_q, sleep_req_q, init_req_q};
                OFS_MSR: begin
                    rdata_d[MSR_INIT_ACKNOWLEDGE_BIT] = (mode_q == MODE_INIT); // RQ2 RQ4 RQ10
                    rdata_d[MSR_LOWPOWER_ACKNOWLEDGE_BIT] = lowpower_acknowledge_q;                // RQ2 RQ13
                    rdata_d[MSR_WAKE_BIT] = wake_flag_q;
                    rdata_d[MSR_RX_BIT]   = rx_pin_i;
                end
                OFS_IER:  rdata_d[IER_WAKE_BIT] = wake_ie_q;
                OFS_DIAG: rdata_d[1:0] = {loopback_q, silent_q};
                OFS_TSR: begin
                    for (int i = 0; i < NUM_MBOX; i++) begin
                        rdata_d[i*TSR_STRIDE +: 4] = mb_flg[i]; // RQ21
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            avs_readdata_o <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// ---- can_mode_pkg.sv ----
// Purpose: Shared constants and types for the CAN mode and transmit mailbox controller
// Assumes: 32-bit word-aligned register bus, byte addresses below
// Notes:   Two transmit mailboxes, one register page per mailbox
package can_mode_pkg;

    localparam int unsigned IDLE_BITS = 11;
    localparam int unsigned NUM_MBOX  = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_MCR   = 8'h00;
    localparam logic [7:0] OFS_MSR   = 8'h04;
    localparam logic [7:0] OFS_IER   = 8'h08;
    localparam logic [7:0] OFS_DIAG  = 8'h0C;
    localparam logic [7:0] OFS_TSR   = 8'h10;
    localparam logic [1:0] MB_REGION = 2'h1;
    localparam logic [2:0] MBF_CSR   = 3'h0;
    localparam logic [2:0] MBF_ID    = 3'h1;
    localparam logic [2:0] MBF_DLC   = 3'h2;
    localparam logic [2:0] MBF_DATA0 = 3'h3;
    localparam logic [2:0] MBF_DATA1 = 3'h4;

    // Field positions
    localparam int unsigned MCR_INIT_BIT  = 0;
    localparam int unsigned MCR_SLEEP_BIT = 1;
    localparam int unsigned MCR_AWAKE_BIT = 2;
    localparam int unsigned MSR_INIT_ACKNOWLEDGE_BIT  = 0;
    localparam int unsigned MSR_LOWPOWER_ACKNOWLEDGE_BIT  = 1;
    localparam int unsigned MSR_WAKE_BIT  = 2;
    localparam int unsigned MSR_RX_BIT    = 3;
    localparam int unsigned IER_WAKE_BIT  = 0;
    localparam int unsigned DIAG_SIL_BIT  = 0;
    localparam int unsigned DIAG_LBK_BIT  = 1;
    localparam int unsigned CSR_TRANSMIT_REQUEST_BIT  = 0;
    localparam int unsigned CSR_FLAG_LSB  = 1;
    localparam int unsigned CSR_STATE_LSB = 8;
    localparam int unsigned ID_IDE_BIT    = 29;
    localparam int unsigned TSR_STRIDE    = 8;

    // Mailbox flag order inside the 4-bit flag vector
    localparam int unsigned FLG_REQUEST_COMPLETE = 0;
    localparam int unsigned FLG_TRANSMIT_SUCCESS = 1;
    localparam int unsigned FLG_ARBITRATION_LOST = 2;
    localparam int unsigned FLG_TRANSMIT_ERROR = 3;

    // Reset values
    localparam logic [2:0] MCR_RESET  = 3'h2;
    localparam logic [1:0] DIAG_RESET = 2'h0;

    typedef enum logic [1:0] {MB_EMPTY, MB_PENDING, MB_SCHEDULED, MB_TRANSMIT} mb_state_t;
    typedef enum logic [1:0] {MODE_SLEEP, MODE_INIT, MODE_SYNC, MODE_NORMAL} mode_t;

    typedef struct packed {
        logic [28:0] id;
        logic        ide;
        logic [3:0]  dlc;
        logic [63:0] data;
    } tx_frame_t;

    typedef struct packed {
        logic done;
        logic ok;
        logic arb_lost;
        logic error;
    } tx_result_t;

endpackage

// ---- can_idle_detect.sv ----
// Purpose: Bus idle detector, counts consecutive recessive bits
// Assumes: bit_tick_i marks one sample point per bit time
// Notes:   Restart clears the run so each sync waits afresh
`timescale 1ns/1ps
`default_nettype none
module can_idle_detect
    import can_mode_pkg::*;
#(
    parameter int unsigned BITS = IDLE_BITS
) (
    input  wire logic clk_sys_i,  // System clock
    input  wire logic rst_i,      // Sync reset, high
    input  wire logic ce_i,       // Clock enable
    input  wire logic restart_i,  // Forget the current run
    input  wire logic bit_tick_i, // Sample point strobe
    input  wire logic rx_bit_i,   // Receive path level
    output logic      idle_o      // Run of recessive bits reached
);
    logic [4:0] run_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            run_q <= 5'h00;
        end else if (ce_i) begin
            if (restart_i || (bit_tick_i && !rx_bit_i)) begin
                run_q <= 5'h00;
            end else if (bit_tick_i && run_q != BITS[4:0]) begin
                run_q <= run_q + 5'h01; // RQ3
            end
        end
    end

    assign idle_o = (run_q == BITS[4:0]);
endmodule
`default_nettype wire

// ---- can_tx_mailbox.sv ----
// Purpose: One transmit mailbox life cycle and its completion flags
// Assumes: Result strobes arrive only while this mailbox transmits
// Notes:   A failed attempt returns to pending for automatic retry
`timescale 1ns/1ps
`default_nettype none
module can_tx_mailbox
    import can_mode_pkg::*;
(
    input  wire logic       clk_sys_i, // System clock
    input  wire logic       rst_i,     // Sync reset, high
    input  wire logic       ce_i,      // Clock enable
    input  wire logic       request_i, // Transmit request write
    input  wire logic       winner_i,  // Highest priority pending
    input  wire logic       start_i,   // Transmission begins
    input  wire tx_result_t result_i,  // Attempt outcome
    input  wire logic [3:0] clr_i,     // Flag clear strobes
    output mb_state_t       state_o,   // Life cycle state
    output logic [3:0]      flags_o    // Completion flags
);
    mb_state_t  st_q;
    logic [3:0] flg_q;
    logic [3:0] flg_d;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= MB_EMPTY;
        end else if (ce_i) begin
            unique case (st_q)
                MB_EMPTY: begin
                    if (request_i) begin
                        st_q <= MB_PENDING; // RQ20
                    end
                end
                MB_PENDING: begin
                    if (winner_i) begin
                        st_q <= MB_SCHEDULED; // RQ20
                    end
                end
                MB_SCHEDULED: begin
                    if (start_i) begin
                        st_q <= MB_TRANSMIT; // RQ20
                    end else if (!winner_i) begin
                        st_q <= MB_PENDING;
                    end
                end
                MB_TRANSMIT: begin
                    if (result_i.done) begin
                        st_q <= result_i.ok ? MB_EMPTY : MB_PENDING; // RQ20
                    end
                end
            endcase
        end
    end

    // Hardware set applied after software clear, so a coincident event survives
    always_comb begin
        flg_d = flg_q & ~clr_i;
        if (request_i && st_q == MB_EMPTY) begin
            flg_d = 4'h0;
        end
        if (st_q == MB_TRANSMIT && result_i.done) begin
            if (result_i.ok) begin
                flg_d[FLG_REQUEST_COMPLETE] = 1'b1; // RQ21
                flg_d[FLG_TRANSMIT_SUCCESS] = 1'b1; // RQ21
            end else begin
                flg_d[FLG_TRANSMIT_SUCCESS] = 1'b0;
                flg_d[FLG_ARBITRATION_LOST] = flg_d[FLG_ARBITRATION_LOST] | result_i.arb_lost; // RQ22
                flg_d[FLG_TRANSMIT_ERROR] = flg_d[FLG_TRANSMIT_ERROR] | result_i.error;    // RQ22
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flg_q <= 4'h0;
        end else if (ce_i) begin
            flg_q <= flg_d;
        end
    end

    assign state_o = st_q;
    assign flags_o = flg_q;
endmodule
`default_nettype wire

// ---- can_bus_model.sv ----
// Purpose: Bus line and protocol core stand-in
// Assumes: Bit time of 4 clocks
// Notes:   Every attempt succeeds 6 cycles after start
`timescale 1ns/1ps
`default_nettype none
module can_bus_model
    import can_mode_pkg::*;
(
    input  wire logic  clk_sys_i, // System clock
    input  wire logic  tx_pin_i,  // Node transmit level
    input  wire logic  dom_i,     // Other node drives dominant
    input  wire logic  start_i,   // Attempt starts
    output logic       rx_pin_o,  // Wired-AND bus level
    output logic       tick_o,    // Bit sample strobe
    output tx_result_t res_o      // Attempt outcome
);
    logic [2:0] cnt_q = 3'h0;
    logic [3:0] dly_q = 4'h0;
    // Dominant from any node wins the wire
    assign rx_pin_o = tx_pin_i & ~dom_i;
    assign tick_o   = cnt_q == 3'h3;
    assign res_o    = '{dly_q == 4'h1, dly_q == 4'h1, 1'b0, 1'b0};
    always_ff @(posedge clk_sys_i) begin
        cnt_q <= tick_o ? 3'h0 : cnt_q + 3'h1;
        dly_q <= start_i ? 4'h6 : (dly_q != 4'h0 ? dly_q - 4'h1 : 4'h0);
    end
endmodule
`default_nettype wire

// ---- can_mode_props.sv ----
// Purpose: Port checks for the mode controller
// Assumes: Single clock domain
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module can_mode_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic avs_read_i,
    input wire logic avs_waitrequest_o,
    input wire logic tx_pin_o,
    input wire logic core_clk_en_o,
    input wire logic core_active_o,
    input wire logic core_tx_bit_i,
    input wire logic core_rx_bit_o,
    input wire logic core_bus_idle_i,
    input wire logic ack_err_off_o,
    input wire logic tx_start_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence one_wait_s;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    reset_sleep_a: assert property ($fell(rst_i) |-> !core_clk_en_o) else $error("not asleep after reset");
    wait_state_a: assert property ($rose(avs_read_i) && ce_i |-> one_wait_s) else $error("wait state wrong");
    quiet_tx_a: assert property (!core_active_o |-> tx_pin_o) else $error("tx driven while inactive");
    sleep_idle_a: assert property (!core_clk_en_o |-> !core_active_o) else $error("active in sleep");
    wake_sync_a: assert property ($rose(core_clk_en_o) |-> !core_active_o [*2]) else $error("no sync");
    start_pulse_a: assert property (tx_start_o |=> !tx_start_o) else $error("start too long");
    start_cond_a: assert property (tx_start_o |-> core_active_o && core_bus_idle_i) else $error("bad start");
    loop_feed_a: assert property (ack_err_off_o && core_active_o |-> core_rx_bit_o == core_tx_bit_i)
        else $error("loop path broken");
endmodule
bind can_mode_ctrl can_mode_props chk (.*);
`default_nettype wire

// ---- test_can_mode_ctrl.sv ----
// Purpose: Register level test of the mode controller
// Assumes: Avalon accesses with one wait state
// Notes:   Wake, init, loop-back and two mailboxes
`timescale 1ns/1ps
`default_nettype none
module test_can_mode_ctrl;
    import can_mode_pkg::*;
    logic clk_sys_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, rx_pin_i, tx_pin_o, dom;
    logic core_clk_en_o, core_active_o, core_tx_bit_i, core_rx_bit_o, bit_tick_i, core_bus_idle_i;
    logic ack_err_off_o, tx_start_o, wakeup_irq_o;
    logic [7:0] avs_address_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    tx_frame_t tx_frame_o;
    tx_result_t tx_result_i;
    int error_cnt = 0, n_tests = 0;
    can_mode_ctrl uut (.*);
    can_bus_model bus (.clk_sys_i(clk_sys_i), .tx_pin_i(tx_pin_o), .dom_i(dom), .start_i(tx_start_o),
        .rx_pin_o(rx_pin_i), .tick_o(bit_tick_i), .res_o(tx_result_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        {avs_write_i, avs_read_i, avs_address_i, avs_writedata_i} <= {w, !w, a, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        rd = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'h0;
        if (n == 50) begin error_cnt++; results(); end
    endtask
    task automatic wt(input int b, input logic v);
        for (int i = 0; i < 60; i++) begin
            acc(1'b0, OFS_MSR, 32'h0);
            if (rd[b] === v) return;
        end
        error_cnt++;
        results();
    endtask
    task automatic ws(input logic [31:0] id);
        int n;
        for (n = 0; n < 300 && tx_start_o !== 1'b1; n++) @(negedge clk_sys_i);
        if (n == 300) begin error_cnt++; results(); end
        @(negedge clk_sys_i);
        chk({3'h0, tx_frame_o.id}, id);
    endtask
    initial begin
        {rst_i, ce_i, core_bus_idle_i, core_tx_bit_i, avs_byteenable_i} = 8'hFF;
        {avs_read_i, avs_write_i, dom, avs_address_i, avs_writedata_i} = '0;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        acc(1'b0, OFS_MSR, 32'h0); chk(rd, 32'hA);
        acc(1'b0, OFS_MCR, 32'h0); chk(rd, 32'h2);
        acc(1'b1, OFS_IER, 32'h1);
        acc(1'b1, OFS_MCR, 32'h7);
        acc(1'b0, OFS_MSR, 32'h0); chk(rd, 32'hA);
        dom <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        dom <= 1'b0;
        chk(wakeup_irq_o, 32'h1);
        wt(MSR_INIT_ACKNOWLEDGE_BIT, 1'b1);
        chk(rd, 32'hD);
        chk(tx_pin_o, 32'h1);
        acc(1'b0, OFS_MCR, 32'h0); chk(rd, 32'h5);
        acc(1'b1, OFS_MSR, 32'h4);
        acc(1'b1, OFS_DIAG, 32'h2);
        acc(1'b0, OFS_DIAG, 32'h0); chk(rd, 32'h2);
        chk(wakeup_irq_o, 32'h0);
        chk(ack_err_off_o, 32'h1);
        acc(1'b1, 8'h44, 32'h5);
        acc(1'b1, 8'h64, 32'h3);
        acc(1'b1, 8'h40, 32'h1);
        acc(1'b1, 8'h60, 32'h1);
        acc(1'b1, OFS_MCR, 32'h0);
        ws(32'h3);
        ws(32'h5);
        repeat (8) @(posedge clk_sys_i);
        acc(1'b0, 8'h40, 32'h0); chk(rd, 32'h6);
        acc(1'b0, OFS_TSR, 32'h0); chk(rd, 32'h303);
        results();
    end
endmodule
`default_nettype wire
